// [hdl/spo_top.sv]
// Suspend pin override, pin configuration and control report handling
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Without override, pins keep pre-suspend outputs throughout suspend.
// - Override in suspend: pins follow suspend level and behaviour bits.
// - Under override, a clock-configured pin 0 stops and drives low.
// - Under override, an RS-485 direction pin 1 or 3 stays deasserted.
// - Pins 0-3, 4-5, 6-9 map to bits 3:0, 7:6, 13:10; rest reserved, except behaviour bit 15, the override.
// - Receive pin is always serial data input, never reconfigured.
// - Pin configuration codes take their fixed defaults at reset.
// - Language report: id 0x67, then low byte, then high byte.
// - Language code reads 0x0409 until the host writes another.
// - Lock report: id 0x68, bit 0 of byte 1 requests lock.
// - A lock request only takes effect after the next reset.
// - Status function 001 is high in suspend; the inverted one complements.
module spo_top #(
    parameter int NPIN = 10
) (
    input  wire logic            clk_sys,     // system clock, 200 MHz
    input  wire logic            rstn,        // asynchronous reset
    input  wire logic            ce,          // clock enable
    input  wire logic            usb_suspended, // USB suspend level
    input  wire logic            usb_bus_rst, // USB bus reset level
    input  wire logic            usb_configured, // device configured
    input  wire logic            lock_strap,  // stored lock request
    output logic                 lock_req_nv, // lock request to store
    output logic                 lock_active, // configuration locked
    input  wire logic            rpt_sof,     // first byte of a report
    input  wire logic            rpt_wr,      // byte written by host
    input  wire logic [7:0]      rpt_wdata,   // written byte
    input  wire logic            rpt_rd,      // byte read by host
    output logic [7:0]           rpt_rdata,   // read byte
    output logic                 rpt_rvalid,  // read byte valid
    output logic [15:0]          language_code, // current language code
    input  wire logic [NPIN-1:0] gpio_drive,  // plain output values
    input  wire logic            pin0_clock_out, // clock for pin 0
    input  wire logic            rts_n,       // request to send
    input  wire logic            dtr_n,       // data terminal ready
    input  wire logic            rs485_de,    // RS-485 direction enable
    input  wire logic            transmit_activity_toggle, // tx activity
    input  wire logic            receive_activity_toggle,  // rx activity
    input  wire logic            tx_data,     // serial data to send
    input  wire logic [NPIN-1:0] gpio_i,      // pin levels
    output logic [NPIN-1:0]      gpio_o,      // pin output levels
    output logic [NPIN-1:0]      gpio_oe,     // pin output enables
    output logic [NPIN-1:0]      gpio_in,     // sampled pin levels
    output logic                 tx_o,        // transmit pin level
    output logic                 tx_oe,       // transmit pin enable
    input  wire logic            rx_pin,      // receive pin
    output logic                 rx_data,     // serial data received
    output logic                 usb_status_out_a, // status pin a level
    output logic                 usb_status_out_a_oe, // status a enable
    output logic                 usb_status_out_b, // status pin b level
    output logic                 usb_status_out_b_oe  // status b enable
);
    spo_pkg::spo_state_t st;
    spo_pkg::spo_state_t next_st;
    logic [NPIN-1:0] alt_src;
    logic [NPIN-1:0] pin_nx_o;
    logic [NPIN-1:0] pin_nx_oe;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Status pin level for a function code; code 000 asserts only on pin a
    function automatic logic stat_level(input logic [2:0] fxn,
                                        input logic is_b,
                                        input logic susp,
                                        input logic brst,
                                        input logic cfgd);
        logic lv;
        lv = 1'b0;
        case (fxn[1:0])
            2'h0: lv = is_b ? 1'b0 : (susp | brst);
            2'h1: lv = susp;
            2'h2: lv = susp | !cfgd;
            2'h3: lv = brst;
            default: lv = 1'b0;
        endcase
        if (fxn[2] && fxn[1:0] != 2'h0)
        begin
            lv = !lv;
        end
        return lv;
    endfunction

    always_comb
    begin
        alt_src = '0;
        alt_src[0] = pin0_clock_out;
        alt_src[1] = rts_n;
        alt_src[3] = rs485_de;
        alt_src[4] = transmit_activity_toggle;
        alt_src[5] = receive_activity_toggle;
        alt_src[8] = dtr_n;
    end

    for (genvar g = 0; g < NPIN; g++)
    begin : g_pin
        spo_pin_drive #(
            .PIN       (g)
        ) u_pin (
            .cfg       (st.code[spo_pkg::IDX_PIN0 + g][2:0]),
            .gpio_val  (gpio_drive[g]),
            .alt_src   (alt_src[g]),
            .dir_src   (rs485_de),
            .suspended (usb_suspended),
            .override  (st.beh[spo_pkg::OVR_BIT]),
            .lvl       (st.lvl[spo_pkg::PIN_BIT[g]]),
            .beh       (st.beh[spo_pkg::PIN_BIT[g]]),
            .cur_o     (st.gpio_o[g]),
            .cur_oe    (st.gpio_oe[g]),
            .next_o    (pin_nx_o[g]),
            .next_oe   (pin_nx_oe[g])
        );
    end

    always_comb
    begin
        logic [7:0] rb;
        logic       lv;
        rb = 8'h00;
        lv = 1'b0;
        next_st = st;
        next_st.gpio_o = pin_nx_o;
        next_st.gpio_oe = pin_nx_oe;
        next_st.gpio_in = gpio_i;
        next_st.rx_data = rx_pin;
        // Lock is sampled once after reset, so a later write waits for reset
        if (!st.lock_seen)
        begin
            next_st.lock_on = lock_strap;
            next_st.lock_seen = 1'b1;
        end
        next_st.rvalid = 1'b0;
        if (rpt_wr && rpt_sof)
        begin
            next_st.rid = rpt_wdata;
            next_st.idx = 5'h01;
        end
        else if (rpt_wr)
        begin
            case (st.rid)
                spo_pkg::RPT_LANG:
                begin
                    if (st.idx == 5'h01)
                        next_st.lang[7:0] = rpt_wdata;
                    if (st.idx == 5'h02)
                        next_st.lang[15:8] = rpt_wdata;
                end
                spo_pkg::RPT_LOCK:
                begin
                    if (st.idx == 5'h01)
                        next_st.lock_req = rpt_wdata;
                end
                spo_pkg::RPT_PINCFG:
                begin
                    if (!st.lock_on)
                    begin
                        if (st.idx != 5'h00 && st.idx <= spo_pkg::PC_CODE_LAST)
                            next_st.code[4'(st.idx - 5'h01)] = rpt_wdata;
                        if (st.idx == spo_pkg::PC_LVL_LO)
                            next_st.lvl[7:0] = rpt_wdata
                                             & spo_pkg::LVL_MASK[7:0];
                        if (st.idx == spo_pkg::PC_LVL_HI)
                            next_st.lvl[15:8] = rpt_wdata
                                              & spo_pkg::LVL_MASK[15:8];
                        if (st.idx == spo_pkg::PC_BEH_LO)
                            next_st.beh[7:0] = rpt_wdata
                                             & spo_pkg::BEH_MASK[7:0];
                        if (st.idx == spo_pkg::PC_BEH_HI)
                            next_st.beh[15:8] = rpt_wdata
                                              & spo_pkg::BEH_MASK[15:8];
                    end
                end
                default: ;
            endcase
            if (st.idx != 5'h1f)
                next_st.idx = st.idx + 5'h01;
        end
        else if (rpt_rd)
        begin
            case (st.rid)
                spo_pkg::RPT_LANG:
                    rb = (st.idx == 5'h01) ? st.lang[7:0]
                       : (st.idx == 5'h02) ? st.lang[15:8] : 8'h00;
                spo_pkg::RPT_LOCK:
                    rb = (st.idx == 5'h01) ? st.lock_req : 8'h00;
                spo_pkg::RPT_PINCFG:
                begin
                    if (st.idx != 5'h00 && st.idx <= spo_pkg::PC_CODE_LAST)
                        rb = st.code[4'(st.idx - 5'h01)];
                    else if (st.idx == spo_pkg::PC_LVL_LO)
                        rb = st.lvl[7:0];
                    else if (st.idx == spo_pkg::PC_LVL_HI)
                        rb = st.lvl[15:8];
                    else if (st.idx == spo_pkg::PC_BEH_LO)
                        rb = st.beh[7:0];
                    else if (st.idx == spo_pkg::PC_BEH_HI)
                        rb = st.beh[15:8];
                end
                default: rb = 8'h00;
            endcase
            next_st.rdata = rb;
            next_st.rvalid = 1'b1;
            if (st.idx != 5'h1f)
                next_st.idx = st.idx + 5'h01;
        end
        // Transmit pin: open drain releases on a one bit
        next_st.tx_o = 1'b0;
        next_st.tx_oe = 1'b0;
        if (st.code[spo_pkg::IDX_TX][1:0] == spo_pkg::DRV_OD)
            next_st.tx_oe = !tx_data;
        else if (st.code[spo_pkg::IDX_TX][1:0] == spo_pkg::DRV_PP)
        begin
            next_st.tx_o = tx_data;
            next_st.tx_oe = 1'b1;
        end
        lv = stat_level(st.code[spo_pkg::IDX_STAT_A][4:2], 1'b0,
                        usb_suspended, usb_bus_rst, usb_configured);
        next_st.stat_a_o = 1'b0;
        next_st.stat_a_oe = 1'b0;
        if (st.code[spo_pkg::IDX_STAT_A][1:0] == spo_pkg::DRV_OD)
            next_st.stat_a_oe = !lv;
        else if (st.code[spo_pkg::IDX_STAT_A][1:0] == spo_pkg::DRV_PP)
        begin
            next_st.stat_a_o = lv;
            next_st.stat_a_oe = 1'b1;
        end
        lv = stat_level(st.code[spo_pkg::IDX_STAT_B][4:2], 1'b1,
                        usb_suspended, usb_bus_rst, usb_configured);
        next_st.stat_b_o = 1'b0;
        next_st.stat_b_oe = 1'b0;
        if (st.code[spo_pkg::IDX_STAT_B][1:0] == spo_pkg::DRV_OD)
            next_st.stat_b_oe = !lv;
        else if (st.code[spo_pkg::IDX_STAT_B][1:0] == spo_pkg::DRV_PP)
        begin
            next_st.stat_b_o = lv;
            next_st.stat_b_oe = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.code <= spo_pkg::CODE_RST;
            st.lang <= spo_pkg::LANG_RST;
            st.lock_req <= spo_pkg::LOCK_RST;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign lock_req_nv = st.lock_req[0];
    assign lock_active = st.lock_on;
    assign rpt_rdata = st.rdata;
    assign rpt_rvalid = st.rvalid;
    assign language_code = st.lang;
    assign gpio_o = st.gpio_o;
    assign gpio_oe = st.gpio_oe;
    assign gpio_in = st.gpio_in;
    assign tx_o = st.tx_o;
    assign tx_oe = st.tx_oe;
    assign rx_data = st.rx_data;
    assign usb_status_out_a = st.stat_a_o;
    assign usb_status_out_a_oe = st.stat_a_oe;
    assign usb_status_out_b = st.stat_b_o;
    assign usb_status_out_b_oe = st.stat_b_oe;

    a_retain_pins: assert property (
        ce && usb_suspended && !st.beh[spo_pkg::OVR_BIT]
        |=> gpio_o == $past(gpio_o) && gpio_oe == $past(gpio_oe))
        else $error("pins changed in suspend without override");
    a_override_level: assert property (
        ce && usb_suspended && st.beh[spo_pkg::OVR_BIT] && st.beh[6]
        |=> gpio_oe[4] && gpio_o[4] == $past(st.lvl[6]))
        else $error("pin 4 not at suspend level");
    a_clock_stop: assert property (
        ce && usb_suspended && st.beh[spo_pkg::OVR_BIT]
        && st.code[spo_pkg::IDX_PIN0][2:0] == spo_pkg::CFG_ALT_PP
        |=> gpio_oe[0] && !gpio_o[0])
        else $error("clock pin not held low");
    a_dir_off: assert property (
        ce && usb_suspended && st.beh[spo_pkg::OVR_BIT]
        && st.code[spo_pkg::IDX_PIN0 + 3][2:0] == spo_pkg::CFG_ALT_OD
        |=> gpio_oe[3] && !gpio_o[3])
        else $error("direction pin not deasserted");
    a_reserved_zero: assert property (
        (st.lvl & ~spo_pkg::LVL_MASK) == 16'h0000
        && (st.beh & ~spo_pkg::BEH_MASK) == 16'h0000)
        else $error("reserved suspend bit set");
    a_rx_follow: assert property (
        ce |=> rx_data == $past(rx_pin))
        else $error("receive data not following pin");
    a_lang_low: assert property (
        ce && rpt_wr && !rpt_sof && st.rid == spo_pkg::RPT_LANG
        && st.idx == 5'h01 |=> language_code[7:0] == $past(rpt_wdata))
        else $error("language low byte not stored");
    a_lock_read: assert property (
        ce && rpt_rd && !rpt_wr && st.rid == spo_pkg::RPT_LOCK
        && st.idx == 5'h01 |=> rpt_rvalid && rpt_rdata == $past(st.lock_req))
        else $error("lock byte read wrong");
    a_lock_defer: assert property (
        st.lock_seen |=> $stable(lock_active))
        else $error("lock changed without reset");
    a_stat_suspend: assert property (
        ce && st.code[spo_pkg::IDX_STAT_A][4:2] == spo_pkg::FXN_SUSPEND
        && st.code[spo_pkg::IDX_STAT_A][1:0] == spo_pkg::DRV_PP
        |=> usb_status_out_a == $past(usb_suspended))
        else $error("status a not tracking suspend");
    a_resume_normal: assert property (
        ce && !usb_suspended
        && st.code[spo_pkg::IDX_PIN0 + 8][2:0] == spo_pkg::CFG_PP
        |=> gpio_oe[8] && gpio_o[8] == $past(gpio_drive[8]))
        else $error("pin 8 not back to normal drive");
endmodule
`default_nettype wire

// [hdl/spo_pkg.sv]
// Constants and state type for the suspend pin override block
package spo_pkg;
    localparam int NCODE = 13;              // tx, pins 0-9, status a, b
    localparam int IDX_TX = 0;
    localparam int IDX_PIN0 = 1;
    localparam int IDX_STAT_A = 11;
    localparam int IDX_STAT_B = 12;
    localparam logic [NCODE-1:0][7:0] CODE_RST = {
        8'h1a, 8'h0a, 8'h02, 8'h02, 8'h00, 8'h00, 8'h03,
        8'h03, 8'h03, 8'h03, 8'h03, 8'h00, 8'h02};
    localparam logic [7:0]  RPT_PINCFG = 8'h65;
    localparam logic [7:0]  RPT_LANG = 8'h67;
    localparam logic [7:0]  RPT_LOCK = 8'h68;
    localparam logic [4:0]  PC_CODE_LAST = 5'h0d;
    localparam logic [4:0]  PC_LVL_LO = 5'h0e;
    localparam logic [4:0]  PC_LVL_HI = 5'h0f;
    localparam logic [4:0]  PC_BEH_LO = 5'h10;
    localparam logic [4:0]  PC_BEH_HI = 5'h11;
    localparam logic [15:0] LANG_RST = 16'h0409;
    localparam logic [7:0]  LOCK_RST = 8'h00;
    localparam logic [15:0] LVL_MASK = 16'h3ccf;
    localparam logic [15:0] BEH_MASK = 16'hbccf;
    localparam int OVR_BIT = 15;
    localparam logic [9:0][3:0] PIN_BIT = {4'hd, 4'hc, 4'hb, 4'ha, 4'h7,
                                          4'h6, 4'h3, 4'h2, 4'h1, 4'h0};
    localparam logic [9:0]  ALT_OUT = 10'h13b;
    localparam logic [2:0]  CFG_IN = 3'h0;
    localparam logic [2:0]  CFG_OD = 3'h1;
    localparam logic [2:0]  CFG_PP = 3'h2;
    localparam logic [2:0]  CFG_ALT_OD = 3'h3;
    localparam logic [2:0]  CFG_ALT_PP = 3'h4;
    localparam logic [1:0]  DRV_OD = 2'h1;
    localparam logic [1:0]  DRV_PP = 2'h2;
    localparam logic [2:0]  FXN_SUSPEND = 3'h1;

    typedef struct packed {
        logic [NCODE-1:0][7:0] code;
        logic [15:0]           lvl;
        logic [15:0]           beh;
        logic [15:0]           lang;
        logic [7:0]            lock_req;
        logic                  lock_on;
        logic                  lock_seen;
        logic [7:0]            rid;
        logic [4:0]            idx;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [9:0]            gpio_o;
        logic [9:0]            gpio_oe;
        logic [9:0]            gpio_in;
        logic                  tx_o;
        logic                  tx_oe;
        logic                  stat_a_o;
        logic                  stat_a_oe;
        logic                  stat_b_o;
        logic                  stat_b_oe;
        logic                  rx_data;
    } spo_state_t;
endpackage

// [hdl/spo_pin_drive.sv]
// Next output level and enable of one general-purpose pin
`timescale 1ns/10ps
`default_nettype none
module spo_pin_drive #(
    parameter int PIN = 0
) (
    input  wire logic [2:0] cfg,        // pin configuration code
    input  wire logic       gpio_val,   // plain output value
    input  wire logic       alt_src,    // alternate function value
    input  wire logic       dir_src,    // RS-485 direction enable
    input  wire logic       suspended,  // USB suspend level
    input  wire logic       override,   // suspend override enable
    input  wire logic       lvl,        // suspend level bit
    input  wire logic       beh,        // suspend behaviour bit
    input  wire logic       cur_o,      // present output level
    input  wire logic       cur_oe,     // present output enable
    output logic            next_o,     // next output level
    output logic            next_oe     // next output enable
);
    logic alt;
    logic od;
    logic val;
    logic clk_fn;
    logic dir_fn;

    always_comb
    begin
        alt = (cfg == spo_pkg::CFG_ALT_OD) || (cfg == spo_pkg::CFG_ALT_PP);
        od = (cfg == spo_pkg::CFG_OD) ||
             (cfg == spo_pkg::CFG_ALT_OD && (PIN == 1 || PIN == 8));
        clk_fn = (PIN == 0) && alt;
        dir_fn = ((PIN == 3) && alt) ||
                 ((PIN == 1) && cfg == spo_pkg::CFG_ALT_PP);
        val = alt ? (dir_fn ? dir_src : alt_src) : gpio_val;
        next_o = 1'b0;
        next_oe = 1'b0;
        if (suspended && !override)
        begin
            next_o = cur_o;
            next_oe = cur_oe;
        end
        else if (suspended)
        begin
            if (clk_fn || dir_fn)
            begin
                next_oe = 1'b1;
            end
            else if (beh)
            begin
                next_o = lvl;
                next_oe = 1'b1;
            end
        end
        else if (cfg == spo_pkg::CFG_IN || cfg > spo_pkg::CFG_ALT_PP ||
                 (alt && !spo_pkg::ALT_OUT[PIN]))
        begin
            next_oe = 1'b0;
        end
        else if (od)
        begin
            next_oe = !val;
        end
        else
        begin
            next_o = val;
            next_oe = 1'b1;
        end
    end
endmodule
`default_nettype wire

// [verif/spo_host_model.sv]
// Host side model: control report bytes and stored lock request
`timescale 1ns/10ps
`default_nettype none
module spo_host_model (
    input  wire logic       clk_sys,     // system clock
    input  wire logic       rstn,        // reset, active low
    input  wire logic       lock_req_nv, // lock request to store
    input  wire logic [7:0] rpt_rdata,   // read byte
    input  wire logic       rpt_rvalid,  // read byte valid
    output logic            lock_strap,  // stored lock request
    output logic            rpt_sof,     // report id marker
    output logic            rpt_wr,      // write strobe
    output logic [7:0]      rpt_wdata,   // written byte
    output logic            rpt_rd       // read strobe
);
    logic nv_bit = 1'b0;
    assign lock_strap = nv_bit;
    // Store outlives device reset, so it follows only out of reset
    always @(posedge clk_sys)
        if (rstn)
            nv_bit <= lock_req_nv;
    initial
    begin
        {rpt_sof, rpt_wr, rpt_rd} = 3'h0;
        rpt_wdata = 8'h00;
    end
    // Flow control pins are never relied on for handshaking
    task automatic put(input logic sof, input logic [7:0] b);
        @(negedge clk_sys);
        {rpt_sof, rpt_wr} = {sof, 1'b1};
        rpt_wdata = b;
        @(negedge clk_sys);
        {rpt_sof, rpt_wr} = 2'h0;
        rpt_wdata = ~b;
    endtask
    task automatic get(output logic [7:0] d, output logic v);
        @(negedge clk_sys);
        rpt_rd = 1'b1;
        @(negedge clk_sys);
        {v, d} = {rpt_rvalid, rpt_rdata};
        rpt_rd = 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/suspend_pin_override_tb_top.sv]
// Testbench: pin defaults, suspend behaviour and control reports
`timescale 1ns/10ps
`default_nettype none
module suspend_pin_override_tb_top;
    localparam logic [7:0] DFLT [13] = '{8'h02, 8'h00, 8'h03, 8'h03, 8'h03,
        8'h03, 8'h03, 8'h00, 8'h00, 8'h02, 8'h02, 8'h0a, 8'h1a};
    localparam logic [7:0] TAIL [4] = '{8'hff, 8'hff, 8'hff, 8'hdf};
    localparam logic [7:0] BACK [4] = '{8'hcf, 8'h3c, 8'hcf, 8'h9c};
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        susp = 1'b0;
    logic        cfgd = 1'b1;
    logic        clk_src = 1'b0;
    logic        de_src = 1'b0;
    logic        tx_data = 1'b0;
    logic        rx_pin = 1'b0;
    logic [9:0]  drive = 10'h000;
    logic [9:0]  ext = 10'h2aa;
    logic        strap, lreq, lact, sof, wr, rd, rv, tx_o, tx_oe, rx_data;
    logic        sa, sa_oe, sb, sb_oe;
    logic [7:0]  wdata, rdata;
    logic [15:0] lang;
    logic [9:0]  gpio_o, gpio_oe, gpio_in;
    wire  [9:0]  gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext);
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    spo_top u_spo_top (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .usb_suspended(susp), .usb_bus_rst(1'b0), .usb_configured(cfgd),
        .lock_strap(strap), .lock_req_nv(lreq), .lock_active(lact),
        .rpt_sof(sof), .rpt_wr(wr), .rpt_wdata(wdata), .rpt_rd(rd),
        .rpt_rdata(rdata), .rpt_rvalid(rv), .language_code(lang),
        .gpio_drive(drive), .pin0_clock_out(clk_src), .rts_n(1'b1),
        .dtr_n(1'b1), .rs485_de(de_src), .transmit_activity_toggle(1'b0),
        .receive_activity_toggle(1'b0), .tx_data(tx_data), .gpio_i(gpio_i),
        .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .tx_o(tx_o),
        .tx_oe(tx_oe), .rx_pin(rx_pin), .rx_data(rx_data),
        .usb_status_out_a(sa), .usb_status_out_a_oe(sa_oe),
        .usb_status_out_b(sb), .usb_status_out_b_oe(sb_oe));
    spo_host_model u_spo_host_model (.clk_sys(clk_sys), .rstn(rstn),
        .lock_req_nv(lreq), .rpt_rdata(rdata), .rpt_rvalid(rv),
        .lock_strap(strap), .rpt_sof(sof), .rpt_wr(wr), .rpt_wdata(wdata),
        .rpt_rd(rd));

    initial
        forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            stop_test;
        end
    end
    task automatic stop_test;
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick;
        @(negedge clk_sys);
    endtask
    task automatic do_reset;
        rstn = 1'b0;
        repeat (3) tick;
        rstn = 1'b1;
        tick;
    endtask
    task automatic t_defaults;
        logic [7:0] d;
        logic       v;
        chk("lang", lang, 16'h0409);
        u_spo_host_model.put(1'b1, 8'h65);
        for (int i = 0; i < 13; i++)
        begin
            u_spo_host_model.get(d, v);
            chk("code", {7'h00, v, d}, {8'h01, DFLT[i]});
        end
        u_spo_host_model.put(1'b1, 8'h68);
        u_spo_host_model.get(d, v);
        chk("lock byte", {7'h00, v, d}, 16'h0100);
    endtask
    task automatic t_lang;
        logic [7:0] d;
        logic       v;
        u_spo_host_model.put(1'b1, 8'h67);
        u_spo_host_model.put(1'b0, 8'h34);
        u_spo_host_model.put(1'b0, 8'h12);
        chk("lang", lang, 16'h1234);
        u_spo_host_model.put(1'b1, 8'h67);
        u_spo_host_model.get(d, v);
        chk("lang lo", {7'h00, v, d}, 16'h0134);
    endtask
    task automatic t_keep;
        drive = 10'h300;
        tick;
        chk("pp out", {14'h0, gpio_o[9:8]}, 16'h0003);
        susp = 1'b1;
        tick;
        drive = 10'h000;
        repeat (2) tick;
        chk("frozen", {14'h0, gpio_o[9:8]}, 16'h0003);
        susp = 1'b0;
        tick;
        chk("resume", {14'h0, gpio_o[9:8]}, 16'h0000);
        ce = 1'b0;
        drive = 10'h300;
        repeat (2) tick;
        chk("ce hold", {14'h0, gpio_o[9:8]}, 16'h0000);
        ce = 1'b1;
    endtask
    task automatic t_override;
        logic [7:0] d;
        logic       v;
        u_spo_host_model.put(1'b1, 8'h65);
        for (int i = 0; i < 17; i++)
            u_spo_host_model.put(1'b0, i > 12 ? TAIL[i-13] :
                                 (i == 1 || i == 2) ? 8'h04 :
                                 i == 11 ? 8'h06 : i == 12 ? 8'h16 : DFLT[i]);
        u_spo_host_model.put(1'b1, 8'h65);
        for (int i = 0; i < 17; i++)
        begin
            u_spo_host_model.get(d, v);
            if (i > 12)
                chk("field", {7'h00, v, d}, {8'h01, BACK[i-13]});
        end
        {clk_src, de_src, susp} = 3'h7;
        tick;
        chk("ovr lvl", {6'h00, gpio_o & gpio_oe}, 16'h01f4);
        chk("ovr oe", {6'h00, gpio_oe}, 16'h01ff);
        chk("status", {12'h0, sa, sb, sa_oe, sb_oe}, 16'h000b);
        susp = 1'b0;
        tick;
        chk("alt out", {13'h0, gpio_o[3], gpio_o[1], gpio_o[0]}, 16'h0007);
        chk("status", {12'h0, sa, sb, sa_oe, sb_oe}, 16'h0007);
    endtask
    task automatic t_rx;
        {rx_pin, tx_data} = 2'h3;
        tick;
        chk("rx tx", {13'h0, rx_data, tx_o, tx_oe}, 16'h0007);
        {rx_pin, tx_data} = 2'h0;
        tick;
        chk("rx tx", {13'h0, rx_data, tx_o, tx_oe}, 16'h0001);
        chk("pin in", {14'h0, gpio_in[7:6]}, 16'h0002);
    endtask
    task automatic t_lock;
        u_spo_host_model.put(1'b1, 8'h68);
        u_spo_host_model.put(1'b0, 8'h01);
        chk("lock req", {14'h0, lreq, lact}, 16'h0002);
        tick;
        do_reset;
        chk("locked", {15'h0, lact}, 16'h0001);
    endtask
    initial
    begin
        do_reset;
        t_defaults;
        t_lang;
        t_keep;
        t_override;
        t_rx;
        t_lock;
        stop_test;
    end
endmodule
`default_nettype wire
